// ==== hdl/dpic_defs.svh ====
// constants for the indirect access, control space and repeat instruction layer
`ifndef DPIC_DEFS_SVH
`define DPIC_DEFS_SVH

`define DPIC_SYNC_CHAR   8'h55
`define DPIC_ACK_CHAR    8'h40
`define DPIC_OP_FIELD    7:5
`define DPIC_PTR_FIELD   3:2
`define DPIC_SIZE_FIELD  1:0
`define DPIC_CSADR_FIELD 3:0
`define DPIC_OP_IND_RD   3'h1
`define DPIC_OP_IND_WR   3'h3
`define DPIC_OP_CS_RD    3'h4
`define DPIC_OP_LOOP     3'h5
`define DPIC_OP_CS_WR    3'h6
`define DPIC_PTR_PLAIN   2'h0
`define DPIC_PTR_INC     2'h1
`define DPIC_PTR_REG     2'h2
`define DPIC_ZERO_WORD   32'h0000_0000
`define DPIC_ZERO_BYTE   8'h00
`define DPIC_ZERO_IDX    2'h0
`define DPIC_ONE_IDX     2'h1
`define DPIC_ZERO_GT     3'h0
`define DPIC_ONE_GT      3'h1
`define DPIC_ONE_CNT     8'h01

`endif

// ==== hdl/dpic_pkg.sv ====
// types shared by the instruction layer and its bench
package dpic_pkg;

  // sequencer states
  typedef enum logic [3:0] {
    DPIC_S_SYNC,
    DPIC_S_INSTR,
    DPIC_S_PREP,
    DPIC_S_DATA,
    DPIC_S_BUS,
    DPIC_S_CSRD,
    DPIC_S_CSWR,
    DPIC_S_LOOP,
    DPIC_S_GUARD,
    DPIC_S_TX,
    DPIC_S_ERR
  } dpic_state_t;

  // system bus request carried to the access layer
  typedef struct packed {
    logic        we;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } dpic_bus_req_t;

  // control space write
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] data;
  } dpic_cs_wr_t;

endpackage : dpic_pkg

// ==== hdl/dpic_core.sv ====
// instruction layer: indirect access, control space access, acknowledges and repeat
`timescale 1ns/1ns
`default_nettype none
`include "dpic_defs.svh"

// Notes on behaviour
// - indirect read fetches from pointer address
// - addresses and data up to 32 bits
// - turnaround idle before first read data
// - indirect read can return the pointer itself
// - pointer mode 2 loads pointer, then ack
// - mode 0 writes, mode 1 also post-increments
// - acknowledge every successful indirect write
// - control read: operand address, one byte
// - control read byte after full idle
// - control write stores one whole byte
// - control write data follows, no response
// - loop op loads counter, up to 255
// - loop op width field sizes its value
// - next instruction runs counter plus one
// - replays carry only their data frames
// - any instruction repeatable except loop op
// - only break ends a repeat early
// - each repeated write frame is acknowledged
// - single-byte instructions preceded by sync char
// - error state ignores all until break
// - idle bit count set by turnaround value
module dpic_core
  import dpic_pkg::*;
(
  // clock and reset
  input  wire logic                   core_clk_in,
  input  wire logic                   rst_n_in,
  // received characters and line events
  input  wire logic                   rx_valid_in,
  input  wire logic [7:0]             rx_byte_in,
  input  wire logic                   break_in,
  input  wire logic                   error_in,
  input  wire logic                   bit_tick_in,
  input  wire logic [2:0]             turnaround_idle_count_in,
  // transmitted characters
  output logic                        tx_valid_out,
  output logic [7:0]                  tx_byte_out,
  input  wire logic                   tx_ready_in,
  // system bus access layer
  output logic                        bus_req_out,
  output dpic_pkg::dpic_bus_req_t     bus_cmd_out,
  input  wire logic                   bus_done_in,
  input  wire logic [31:0]            bus_rdata_in,
  // control and status space
  output logic [3:0]                  cs_rd_addr_out,
  input  wire logic [7:0]             cs_rdata_in,
  output logic                        cs_we_out,
  output dpic_pkg::dpic_cs_wr_t       cs_wr_out,
  // status
  output logic [31:0]                 pointer_out,
  output logic [7:0]                  loop_count_value_out,
  output logic                        repeat_armed_out,
  output logic                        error_state_out
);
  import dpic_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // state
  dpic_state_t   state_r,     state_nxt;
  logic [7:0]    instr_r,     instr_nxt;
  logic [31:0]   ptr_r,       ptr_nxt;
  logic [31:0]   data_r,      data_nxt;
  logic [1:0]    idx_r,       idx_nxt;
  logic [1:0]    last_r,      last_nxt;
  logic [7:0]    rpt_cnt_r,   rpt_cnt_nxt;
  logic          rpt_arm_r,   rpt_arm_nxt;
  logic          guard_req_r, guard_req_nxt;
  logic [2:0]    gt_cnt_r,    gt_cnt_nxt;
  logic [7:0]    tx_byte_r,   tx_byte_nxt;
  dpic_bus_req_t bus_r,       bus_nxt;
  logic          bus_req_r,   bus_req_nxt;
  logic [3:0]    cs_rd_r,     cs_rd_nxt;
  dpic_cs_wr_t   cs_wr_r,     cs_wr_nxt;
  logic          cs_we_r,     cs_we_nxt;
  logic          fin;
  logic [31:0]   step;

  ////////////////////////////////////////////////////////////////////////////////
  // next-state computation
  always_comb begin
    state_nxt     = state_r;
    instr_nxt     = instr_r;
    ptr_nxt       = ptr_r;
    data_nxt      = data_r;
    idx_nxt       = idx_r;
    last_nxt      = last_r;
    rpt_cnt_nxt   = rpt_cnt_r;
    rpt_arm_nxt   = rpt_arm_r;
    guard_req_nxt = guard_req_r;
    gt_cnt_nxt    = gt_cnt_r;
    bus_nxt       = bus_r;
    bus_req_nxt   = bus_req_r;
    cs_rd_nxt     = cs_rd_r;
    cs_wr_nxt     = cs_wr_r;
    cs_we_nxt     = 1'b0;
    fin           = 1'b0;
    // post-increment step is the data size in bytes, reads included
    step          = {30'h0000_0000, instr_r[`DPIC_SIZE_FIELD]} + 32'h0000_0001;
    // any character received outside the error state means the next response needs the line turned round
    if (rx_valid_in && state_r != DPIC_S_ERR) begin
      guard_req_nxt = 1'b1;
    end
    unique case (state_r)
      DPIC_S_SYNC: begin
        // anything but the sync character is dropped while waiting
        if (rx_valid_in && rx_byte_in == `DPIC_SYNC_CHAR) begin
          state_nxt = DPIC_S_INSTR;
        end
      end
      DPIC_S_INSTR: begin
        if (rx_valid_in) begin
          instr_nxt = rx_byte_in;
          idx_nxt   = `DPIC_ZERO_IDX;
          if (rx_byte_in[`DPIC_OP_FIELD] == `DPIC_OP_LOOP) begin
            // a loop op is never repeated: it ends any armed repeat and reloads
            rpt_arm_nxt = 1'b0;
            rpt_cnt_nxt = `DPIC_ZERO_BYTE;
            state_nxt   = DPIC_S_LOOP;
          end else begin
            state_nxt = DPIC_S_PREP;
          end
        end
      end
      // decode point for every execution except the loop op, first or replayed
      DPIC_S_PREP: begin
        idx_nxt  = `DPIC_ZERO_IDX;
        data_nxt = `DPIC_ZERO_WORD;
        unique case (instr_r[`DPIC_OP_FIELD])
          `DPIC_OP_IND_RD: begin
            if (instr_r[`DPIC_PTR_FIELD] == `DPIC_PTR_REG) begin
              data_nxt  = ptr_r;
              last_nxt  = instr_r[`DPIC_SIZE_FIELD];
              state_nxt = DPIC_S_GUARD;
            end else begin
              bus_nxt.we    = 1'b0;
              bus_nxt.size  = instr_r[`DPIC_SIZE_FIELD];
              bus_nxt.addr  = ptr_r;
              bus_nxt.wdata = `DPIC_ZERO_WORD;
              bus_req_nxt   = 1'b1;
              state_nxt     = DPIC_S_BUS;
            end
          end
          `DPIC_OP_IND_WR: state_nxt = DPIC_S_DATA;
          `DPIC_OP_CS_RD: begin
            cs_rd_nxt = instr_r[`DPIC_CSADR_FIELD];
            state_nxt = DPIC_S_CSRD;
          end
          `DPIC_OP_CS_WR: state_nxt = DPIC_S_CSWR;
          default: fin = 1'b1;
        endcase
      end
      DPIC_S_DATA: begin
        if (rx_valid_in) begin
          data_nxt[{idx_r, 3'b000} +: 8] = rx_byte_in;
          idx_nxt                        = idx_r + `DPIC_ONE_IDX;
          if (idx_r == instr_r[`DPIC_SIZE_FIELD]) begin
            idx_nxt = `DPIC_ZERO_IDX;
            if (instr_r[`DPIC_PTR_FIELD] == `DPIC_PTR_REG) begin
              // the pointer load shares the data path; its ack is a one-byte response
              ptr_nxt   = data_nxt;
              data_nxt  = {24'h00_0000, `DPIC_ACK_CHAR};
              last_nxt  = `DPIC_ZERO_IDX;
              state_nxt = DPIC_S_GUARD;
            end else begin
              bus_nxt.we    = 1'b1;
              bus_nxt.size  = instr_r[`DPIC_SIZE_FIELD];
              bus_nxt.addr  = ptr_r;
              bus_nxt.wdata = data_nxt;
              bus_req_nxt   = 1'b1;
              state_nxt     = DPIC_S_BUS;
            end
          end
        end
      end
      DPIC_S_BUS: begin
        if (bus_done_in) begin
          bus_req_nxt = 1'b0;
          if (instr_r[`DPIC_PTR_FIELD] == `DPIC_PTR_INC) begin
            ptr_nxt = ptr_r + step;
          end
          if (bus_r.we) begin
            data_nxt = {24'h00_0000, `DPIC_ACK_CHAR};
            last_nxt = `DPIC_ZERO_IDX;
          end else begin
            // read data is only valid in the done cycle, so it is captured here
            data_nxt = bus_rdata_in;
            last_nxt = instr_r[`DPIC_SIZE_FIELD];
          end
          state_nxt = DPIC_S_GUARD;
        end
      end
      DPIC_S_CSRD: begin
        // the read address was registered a cycle ago, so the byte has settled
        data_nxt  = {24'h00_0000, cs_rdata_in};
        last_nxt  = `DPIC_ZERO_IDX;
        state_nxt = DPIC_S_GUARD;
      end
      DPIC_S_CSWR: begin
        if (rx_valid_in) begin
          cs_wr_nxt.addr = instr_r[`DPIC_CSADR_FIELD];
          cs_wr_nxt.data = rx_byte_in;
          cs_we_nxt      = 1'b1;
          fin            = 1'b1;
        end
      end
      DPIC_S_LOOP: begin
        if (rx_valid_in) begin
          if (idx_r == `DPIC_ZERO_IDX) begin
            // only the first value byte is kept, so counts stop at 255
            rpt_cnt_nxt = rx_byte_in;
          end
          idx_nxt = idx_r + `DPIC_ONE_IDX;
          if (idx_r == instr_r[`DPIC_SIZE_FIELD]) begin
            rpt_arm_nxt = 1'b1;
            state_nxt   = DPIC_S_SYNC;
          end
        end
      end
      DPIC_S_GUARD: begin
        // no idle is needed when nothing was received since the last response
        if (!guard_req_r || gt_cnt_r >= turnaround_idle_count_in) begin
          gt_cnt_nxt    = `DPIC_ZERO_GT;
          guard_req_nxt = 1'b0;
          idx_nxt       = `DPIC_ZERO_IDX;
          state_nxt     = DPIC_S_TX;
        end else if (bit_tick_in) begin
          gt_cnt_nxt = gt_cnt_r + `DPIC_ONE_GT;
        end
      end
      // bytes leave least significant first; the last one ends the execution
      DPIC_S_TX: begin
        if (tx_ready_in) begin
          idx_nxt = idx_r + `DPIC_ONE_IDX;
          if (idx_r == last_r) begin
            idx_nxt = `DPIC_ZERO_IDX;
            fin     = 1'b1;
          end
        end
      end
      DPIC_S_ERR: begin
        // only the break handling below leaves this state
        state_nxt = DPIC_S_ERR;
      end
      default: state_nxt = DPIC_S_SYNC;
    endcase
    // end of one execution: replay from decode or wait for sync again
    // a replay skips the sync and instruction frames and restarts at decode
    if (fin) begin
      if (rpt_arm_r && rpt_cnt_r != `DPIC_ZERO_BYTE) begin
        rpt_cnt_nxt = rpt_cnt_r - `DPIC_ONE_CNT;
        state_nxt   = DPIC_S_PREP;
      end else begin
        rpt_arm_nxt = 1'b0;
        rpt_cnt_nxt = `DPIC_ZERO_BYTE;
        state_nxt   = DPIC_S_SYNC;
      end
    end
    // line errors lock the layer; a break is the only way out or to end a repeat early
    // break is handled last so that it wins over a line error in the same cycle
    if (error_in) begin
      state_nxt   = DPIC_S_ERR;
      bus_req_nxt = 1'b0;
    end
    if (break_in) begin
      state_nxt     = DPIC_S_SYNC;
      rpt_arm_nxt   = 1'b0;
      rpt_cnt_nxt   = `DPIC_ZERO_BYTE;
      bus_req_nxt   = 1'b0;
      guard_req_nxt = 1'b0;
      gt_cnt_nxt    = `DPIC_ZERO_GT;
    end
    // the offered byte follows the next index so it stands together with tx_valid_out
    tx_byte_nxt = data_nxt[{idx_nxt, 3'b000} +: 8];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers
  // synchronous reset, all registers run on every edge
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      state_r     <= DPIC_S_SYNC;
      instr_r     <= `DPIC_ZERO_BYTE;
      ptr_r       <= `DPIC_ZERO_WORD;
      data_r      <= `DPIC_ZERO_WORD;
      idx_r       <= `DPIC_ZERO_IDX;
      last_r      <= `DPIC_ZERO_IDX;
      rpt_cnt_r   <= `DPIC_ZERO_BYTE;
      rpt_arm_r   <= 1'b0;
      guard_req_r <= 1'b0;
      gt_cnt_r    <= `DPIC_ZERO_GT;
      tx_byte_r   <= `DPIC_ZERO_BYTE;
      bus_r       <= '0;
      bus_req_r   <= 1'b0;
      cs_rd_r     <= 4'h0;
      cs_wr_r     <= '0;
      cs_we_r     <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      instr_r     <= instr_nxt;
      ptr_r       <= ptr_nxt;
      data_r      <= data_nxt;
      idx_r       <= idx_nxt;
      last_r      <= last_nxt;
      rpt_cnt_r   <= rpt_cnt_nxt;
      rpt_arm_r   <= rpt_arm_nxt;
      guard_req_r <= guard_req_nxt;
      gt_cnt_r    <= gt_cnt_nxt;
      tx_byte_r   <= tx_byte_nxt;
      bus_r       <= bus_nxt;
      bus_req_r   <= bus_req_nxt;
      cs_rd_r     <= cs_rd_nxt;
      cs_wr_r     <= cs_wr_nxt;
      cs_we_r     <= cs_we_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs
  // valid is decoded from the state so it drops as soon as the last byte is taken
  assign tx_valid_out         = (state_r == DPIC_S_TX);
  assign tx_byte_out          = tx_byte_r;
  assign bus_req_out          = bus_req_r;
  assign bus_cmd_out          = bus_r;
  assign cs_rd_addr_out       = cs_rd_r;
  assign cs_we_out            = cs_we_r;
  assign cs_wr_out            = cs_wr_r;
  assign pointer_out          = ptr_r;
  assign loop_count_value_out = rpt_cnt_r;
  assign repeat_armed_out     = rpt_arm_r;
  assign error_state_out      = (state_r == DPIC_S_ERR);

endmodule : dpic_core
`default_nettype wire

// ==== tb/dpic_core_properties.sv ====
// port checker for the instruction layer
`timescale 1ns/1ns
`default_nettype none
module dpic_core_properties
  import dpic_pkg::*;
(
  // clock, reset and inputs
  input wire logic                    core_clk_in,
  input wire logic                    rst_n_in,
  input wire logic                    break_in,
  input wire logic                    error_in,
  input wire logic                    rx_valid_in,
  input wire logic                    bit_tick_in,
  input wire logic [2:0]              turnaround_idle_count_in,
  input wire logic                    bus_done_in,
  input wire logic                    tx_ready_in,
  // outputs
  input wire logic                    tx_valid_out,
  input wire logic [7:0]              tx_byte_out,
  input wire logic                    bus_req_out,
  input wire dpic_pkg::dpic_bus_req_t bus_cmd_out,
  input wire logic                    cs_we_out,
  input wire logic [7:0]              loop_count_value_out,
  input wire logic                    repeat_armed_out,
  input wire logic                    error_state_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  // bus access steps
  sequence s_wait;
    bus_req_out && !bus_done_in && !break_in && !error_in;
  endsequence
  sequence s_done;
    bus_req_out && bus_done_in;
  endsequence
  a_req_holds: assert property (s_wait |=> bus_req_out && $stable(bus_cmd_out))
    else $error("bus request changed while pending");
  a_req_drops: assert property (s_done |=> !bus_req_out)
    else $error("bus request kept after done");
  sequence s_offer;
    tx_valid_out && !tx_ready_in && !break_in && !error_in;
  endsequence
  a_tx_stands: assert property (s_offer |=> tx_valid_out && $stable(tx_byte_out))
    else $error("offered byte withdrawn");
  a_cs_pulse: assert property (cs_we_out |=> !cs_we_out)
    else $error("control write strobe too long");
  a_cs_silent: assert property (cs_we_out |=> !tx_valid_out [*8])
    else $error("response after control write");
  a_err_silent: assert property (error_state_out && !break_in |=> error_state_out && !tx_valid_out && !bus_req_out)
    else $error("activity in error state");
  a_break_clears: assert property (break_in |=> !repeat_armed_out && !bus_req_out && !error_state_out)
    else $error("break did not clear state");
  a_armed_ends: assert property ($fell(repeat_armed_out) && !$past(break_in) |-> loop_count_value_out == 8'h00)
    else $error("repeat ended with count left");
  // bit periods seen since the last received character, and whether a response is owed
  logic [2:0] idle_seen_r;
  logic       owed_r;
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in || rx_valid_in) begin
      idle_seen_r <= 3'h0;
    end else if (bit_tick_in && idle_seen_r != 3'h7) begin
      idle_seen_r <= idle_seen_r + 3'h1;
    end
    if (!rst_n_in || tx_valid_out) begin
      owed_r <= 1'b0;
    end else if (rx_valid_in) begin
      owed_r <= 1'b1;
    end
  end
  sequence s_first_tx;
    $rose(tx_valid_out) && owed_r;
  endsequence
  a_guard_idle: assert property (s_first_tx |-> idle_seen_r >= turnaround_idle_count_in)
    else $error("response sent before the idle period");
endmodule : dpic_core_properties
bind dpic_core dpic_core_properties u_props (
  .core_clk_in              (core_clk_in),
  .rst_n_in                 (rst_n_in),
  .break_in                 (break_in),
  .error_in                 (error_in),
  .rx_valid_in              (rx_valid_in),
  .bit_tick_in              (bit_tick_in),
  .turnaround_idle_count_in (turnaround_idle_count_in),
  .bus_done_in              (bus_done_in),
  .tx_ready_in              (tx_ready_in),
  .tx_valid_out             (tx_valid_out),
  .tx_byte_out              (tx_byte_out),
  .bus_req_out              (bus_req_out),
  .bus_cmd_out              (bus_cmd_out),
  .cs_we_out                (cs_we_out),
  .loop_count_value_out     (loop_count_value_out),
  .repeat_armed_out         (repeat_armed_out),
  .error_state_out          (error_state_out)
);
`default_nettype wire

// ==== tb/dpic_sys_model.sv ====
// system side model: bus access layer, control space and transmit sink
`timescale 1ns/1ns
`default_nettype none
module dpic_sys_model
  import dpic_pkg::*;
(
  // clock and reset
  input  wire logic                    core_clk_in,
  input  wire logic                    rst_n_in,
  // bus access layer
  input  wire logic                    bus_req_in,
  input  wire dpic_pkg::dpic_bus_req_t bus_cmd_in,
  output logic                         bus_done_out,
  output logic [31:0]                  bus_rdata_out,
  // control space and transmit sink
  input  wire logic [3:0]              cs_rd_addr_in,
  output logic [7:0]                   cs_rdata_out,
  output logic                         tx_ready_out
);
  logic [2:0] wait_r;
  // read data only valid with done, a moving pattern otherwise
  assign bus_done_out  = bus_req_in && (wait_r == 3'h3);
  assign bus_rdata_out = bus_done_out ? ~bus_cmd_in.addr : {29'h0, wait_r};
  assign cs_rdata_out  = {4'hA, cs_rd_addr_in};
  // slow bus answer, sink takes a byte every other cycle
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in || !bus_req_in || bus_done_out) wait_r <= 3'h0;
    else wait_r <= wait_r + 3'h1;
    tx_ready_out <= rst_n_in && !tx_ready_out;
  end
endmodule : dpic_sys_model
`default_nettype wire

// ==== tb/dpic_core_tb.sv ====
// self-checking bench for the instruction layer
`timescale 1ns/1ns
`default_nettype none
module dpic_core_tb;
  import dpic_pkg::*;
  logic core_clk_in, rst_n_in, rx_valid_in, break_in, error_in, bit_tick_in, tx_valid_out, tx_ready_in;
  logic bus_req_out, bus_done_in, cs_we_out, repeat_armed_out, error_state_out;
  logic [7:0]    rx_byte_in, tx_byte_out, cs_rdata_in, loop_count_value_out;
  logic [3:0]    cs_rd_addr_out;
  logic [2:0]    turnaround_idle_count_in;
  logic [1:0]    tick_r;
  logic [31:0]   bus_rdata_in, pointer_out, p;
  logic [15:0]   lfsr_r;
  dpic_bus_req_t bus_cmd_out;
  dpic_cs_wr_t   cs_wr_out;
  logic [7:0]    txq[$];
  logic [63:0]   expq[$];
  int            error_cnt, n_compared, i;
  dpic_core u_dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .rx_valid_in(rx_valid_in),
    .rx_byte_in(rx_byte_in), .break_in(break_in), .error_in(error_in), .bit_tick_in(bit_tick_in),
    .turnaround_idle_count_in(turnaround_idle_count_in), .tx_valid_out(tx_valid_out), .tx_byte_out(tx_byte_out),
    .tx_ready_in(tx_ready_in), .bus_req_out(bus_req_out), .bus_cmd_out(bus_cmd_out), .bus_done_in(bus_done_in),
    .bus_rdata_in(bus_rdata_in), .cs_rd_addr_out(cs_rd_addr_out), .cs_rdata_in(cs_rdata_in), .cs_we_out(cs_we_out),
    .cs_wr_out(cs_wr_out), .pointer_out(pointer_out), .loop_count_value_out(loop_count_value_out),
    .repeat_armed_out(repeat_armed_out), .error_state_out(error_state_out));
  dpic_sys_model u_sys (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .bus_req_in(bus_req_out),
    .bus_cmd_in(bus_cmd_out), .bus_done_out(bus_done_in), .bus_rdata_out(bus_rdata_in),
    .cs_rd_addr_in(cs_rd_addr_out), .cs_rdata_out(cs_rdata_in), .tx_ready_out(tx_ready_in));
  ////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr_next
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic send(input logic [7:0] b);
    @(posedge core_clk_in);
    rx_valid_in <= 1'b1;
    rx_byte_in  <= b;
    @(posedge core_clk_in);
    rx_valid_in <= 1'b0;
  endtask : send
  task automatic cmd(input logic [7:0] b);
    send(8'h55);
    send(b);
  endtask : cmd
  task automatic strobe(input logic e, input logic b);
    @(posedge core_clk_in);
    error_in <= e;
    break_in <= b;
    @(posedge core_clk_in);
    error_in <= 1'b0;
    break_in <= 1'b0;
  endtask : strobe
  task automatic drain();
    int n;
    n = 0;
    while ((txq.size() != 0 || expq.size() != 0) && n < 5000) begin
      @(posedge core_clk_in);
      n++;
    end
    if (n == 5000) error_cnt++;
    repeat (16) @(posedge core_clk_in);
  endtask : drain
  task automatic report_and_stop();
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////
  // clock, bit ticks every fourth cycle, watchdog
  initial begin
    core_clk_in = 1'b0;
    forever #4 core_clk_in = ~core_clk_in;
  end
  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      tick_r      <= 2'h0;
      bit_tick_in <= 1'b0;
    end else begin
      tick_r      <= tick_r + 2'h1;
      bit_tick_in <= (tick_r == 2'h0);
    end
  end
  initial begin
    repeat (60000) @(posedge core_clk_in);
    error_cnt++;
    report_and_stop();
  end
  // compare each accepted byte and completed write with the oldest note
  always @(posedge core_clk_in) begin
    if (tx_valid_out && tx_ready_in)
      check(tx_byte_out, txq.size() != 0 ? txq.pop_front() : {56'h1, tx_byte_out});
    if (bus_req_out && bus_done_in && bus_cmd_out.we)
      check({bus_cmd_out.addr, 16'h0, bus_cmd_out.wdata[15:0]}, expq.size() != 0 ? expq.pop_front() : '1);
    if (cs_we_out)
      check({52'h0, cs_wr_out}, expq.size() != 0 ? expq.pop_front() : '1);
  end
  ////////////////////////////////////////////////////////////
  initial begin
    {rst_n_in, rx_valid_in, rx_byte_in, break_in, error_in} = '0;
    turnaround_idle_count_in = 3'h2;
    lfsr_r = 16'h3D54;
    repeat (16) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    // two-byte pointer load, then plain and post-increment writes
    p = {16'h0, lfsr_r};
    txq.push_back(8'h40);
    cmd(8'h69);
    send(p[7:0]);
    send(p[15:8]);
    drain();
    check(pointer_out, p);
    for (i = 0; i < 2; i++) begin
      lfsr_r = lfsr_next(lfsr_r);
      expq.push_back({p, 16'h0, lfsr_r});
      txq.push_back(8'h40);
      cmd(i != 0 ? 8'h65 : 8'h61);
      send(lfsr_r[7:0]);
      send(lfsr_r[15:8]);
      drain();
      p = p + 32'(2 * i);
      check(pointer_out, p);
    end
    // pointer readback, data read, control space read and write
    txq.push_back(p[7:0]);
    txq.push_back(p[15:8]);
    cmd(8'h29);
    drain();
    txq.push_back(~p[7:0]);
    txq.push_back(~p[15:8]);
    cmd(8'h21);
    drain();
    txq.push_back({4'hA, lfsr_r[3:0]});
    cmd({4'h8, lfsr_r[3:0]});
    drain();
    expq.push_back({52'h0, lfsr_r[3:0], lfsr_r[15:8]});
    cmd({4'hC, lfsr_r[3:0]});
    send(lfsr_r[15:8]);
    drain();
    // repeated post-increment write, one acknowledge per frame
    cmd(8'hA0);
    send(8'h02);
    drain();
    check(loop_count_value_out, 8'h02);
    cmd(8'h65);
    for (i = 0; i < 3; i++) begin
      lfsr_r = lfsr_next(lfsr_r);
      expq.push_back({p, 16'h0, lfsr_r});
      txq.push_back(8'h40);
      send(lfsr_r[7:0]);
      send(lfsr_r[15:8]);
      drain();
      p = p + 32'h2;
    end
    check(repeat_armed_out, 1'b0);
    // 256 streamed reads from a two-byte repeat value
    cmd(8'hA1);
    send(8'hFF);
    send(lfsr_r[7:0]);
    drain();
    check(loop_count_value_out, 8'hFF);
    for (i = 0; i < 256; i++) txq.push_back(~(p[7:0] + 8'(i)));
    cmd(8'h24);
    drain();
    check(pointer_out, p + 32'h100);
    // error state ignores traffic until break; break ends a repeat
    strobe(1'b1, 1'b0);
    cmd(8'h80);
    check(error_state_out, 1'b1);
    drain();
    strobe(1'b0, 1'b1);
    txq.push_back(8'hA0);
    cmd(8'h80);
    drain();
    cmd(8'hA0);
    send(8'h05);
    drain();
    strobe(1'b0, 1'b1);
    @(posedge core_clk_in);
    check(repeat_armed_out, 1'b0);
    report_and_stop();
  end
endmodule : dpic_core_tb
`default_nettype wire
